/* cij_config_init.sv */
// Purpose: configuration phase sequencer, init-done pin, global overrides
//          and boundary-scan test port
// Assumes: tck is its own clock domain; pins arrive asynchronously
// Notes:   frames are written by software through the data register

module cij_config_init #(
  parameter int NUM_FRAMES  = 4,
  parameter int INIT_CYCLES = 16,
  parameter int IO_W        = 8
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // axi4-lite write
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // configuration pins
  input  wire logic              configuration_request_n,
  input  wire logic              user_startup_clock,
  output logic                   initDoneOut,
  output logic                   initDoneOe,
  output logic                   userMode,
  // global overrides
  input  wire logic              global_output_enable,
  input  wire logic              global_register_clear_n,
  input  wire logic [IO_W-1:0]   ioOeUser,
  output logic [IO_W-1:0]        ioOe,
  output logic                   userClear_n,
  // test port
  input  wire logic              tck,
  input  wire logic              tms,
  input  wire logic              tdi,
  output logic                   tdoOut,
  output logic                   tdoOe
);
  localparam int FC_W = $clog2(NUM_FRAMES + 1);
  localparam int IC_W = $clog2(INIT_CYCLES + 1);
  localparam logic [FC_W-1:0] FRAME_LAST = FC_W'(NUM_FRAMES - 1);
  localparam logic [IC_W-1:0] INIT_LAST  = IC_W'(INIT_CYCLES - 1);

  if (NUM_FRAMES < 1 || INIT_CYCLES < 1 || IO_W < 1)
  begin : g_chk
    $error("cij_config_init: counts and widths must be at least one");
  end

  // pin synchronisers: three stages, value accepted when stages 2 and 3 agree
  logic [2:0] reqSync_reg, uclkSync_reg;
  logic       reqFilt_reg, reqFilt_next, uclkFilt_reg, uclkFilt_next;
  logic       uclkRise;

  always_comb
  begin
    reqFilt_next  = reqFilt_reg;
    uclkFilt_next = uclkFilt_reg;
    if (reqSync_reg[1] == reqSync_reg[2])
      reqFilt_next = reqSync_reg[2];
    if (uclkSync_reg[1] == uclkSync_reg[2])
      uclkFilt_next = uclkSync_reg[2];
    uclkRise = uclkFilt_next && !uclkFilt_reg;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reqSync_reg  <= 3'h0;
      uclkSync_reg <= 3'h0;
      reqFilt_reg  <= 1'b0;
      uclkFilt_reg <= 1'b0;
    end
    else
    begin
      reqSync_reg  <= {reqSync_reg[1:0], configuration_request_n};
      uclkSync_reg <= {uclkSync_reg[1:0], user_startup_clock};
      reqFilt_reg  <= reqFilt_next;
      uclkFilt_reg <= uclkFilt_next;
    end
  end

  // axi4-lite slave
  logic        awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
  logic [7:0]  awAddr_reg, awAddr_next, arAddr;
  logic [31:0] wData_reg, wData_next, rData_next;
  logic [3:0]  wStrb_reg, wStrb_next;
  logic        bValid_reg, bValid_next, rValid_reg, rValid_next;
  logic [1:0]  bResp_reg, bResp_next, rResp_next;
  logic        frameWrite;
  logic [cij_pkg::ST_W-1:0] statusWord;

  assign s_axi_awready = !awHeld_reg && !bValid_reg;
  assign s_axi_wready  = !wHeld_reg && !bValid_reg;
  assign s_axi_arready = !rValid_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = bResp_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign arAddr        = s_axi_araddr;

  always_comb
  begin
    awHeld_next = awHeld_reg;
    awAddr_next = awAddr_reg;
    wHeld_next  = wHeld_reg;
    wData_next  = wData_reg;
    wStrb_next  = wStrb_reg;
    bValid_next = bValid_reg;
    bResp_next  = bResp_reg;
    rValid_next = rValid_reg;
    rData_next  = s_axi_rdata;
    rResp_next  = s_axi_rresp;
    frameWrite  = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    if (awHeld_reg && wHeld_reg && !bValid_reg)
    begin
      // frames are whole words; partial strobes are refused
      awHeld_next = 1'b0;
      wHeld_next  = 1'b0;
      bValid_next = 1'b1;
      if (awAddr_reg == cij_pkg::OFF_DATA && wStrb_reg == cij_pkg::STRB_ALL)
      begin
        bResp_next = cij_pkg::RESP_OKAY;
        frameWrite = 1'b1;
      end
      else
        bResp_next = cij_pkg::RESP_SLVERR;
    end
    else if (bValid_reg && s_axi_bready)
      bValid_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rValid_next = 1'b1;
      rResp_next  = cij_pkg::RESP_OKAY;
      rData_next  = 32'h0;
      if (arAddr == cij_pkg::OFF_STATUS)
        rData_next = 32'(statusWord);
      else if (arAddr != cij_pkg::OFF_DATA)
        rResp_next = cij_pkg::RESP_SLVERR;
    end
    else if (rValid_reg && s_axi_rready)
      rValid_next = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      awHeld_reg  <= 1'b0;
      awAddr_reg  <= 8'h0;
      wHeld_reg   <= 1'b0;
      wData_reg   <= 32'h0;
      wStrb_reg   <= 4'h0;
      bValid_reg  <= 1'b0;
      bResp_reg   <= 2'h0;
      rValid_reg  <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      awHeld_reg  <= awHeld_next;
      awAddr_reg  <= awAddr_next;
      wHeld_reg   <= wHeld_next;
      wData_reg   <= wData_next;
      wStrb_reg   <= wStrb_next;
      bValid_reg  <= bValid_next;
      bResp_reg   <= bResp_next;
      rValid_reg  <= rValid_next;
      s_axi_rdata <= rData_next;
      s_axi_rresp <= rResp_next;
    end
  end

  // configuration sequencer
  cij_pkg::cij_phase_t phase_reg, phase_next;
  logic [FC_W-1:0]   frameCnt_reg, frameCnt_next;
  logic [IC_W-1:0]   initCnt_reg, initCnt_next;
  logic [cij_pkg::OPT_W-1:0] opt_reg, opt_next;
  logic              optValid_reg, optValid_next;
  logic              initTick;

  // user clock edges pace init when enabled, else every system cycle
  assign initTick = opt_reg[cij_pkg::OPT_UCLK] ? uclkRise : 1'b1;

  always_comb
  begin
    phase_next    = phase_reg;
    frameCnt_next = frameCnt_reg;
    initCnt_next  = initCnt_reg;
    opt_next      = opt_reg;
    optValid_next = optValid_reg;
    case (phase_reg)
      cij_pkg::PH_IDLE:
      begin
        frameCnt_next = '0;
        initCnt_next  = '0;
        opt_next      = '0;
        optValid_next = 1'b0;
        if (reqFilt_reg)
          phase_next = cij_pkg::PH_CONFIG;
      end
      cij_pkg::PH_CONFIG:
        if (frameWrite)
        begin
          if (frameCnt_reg == '0)
          begin
            opt_next      = wData_reg[cij_pkg::OPT_W-1:0];
            optValid_next = 1'b1;
          end
          frameCnt_next = frameCnt_reg + 1'b1;
          if (frameCnt_reg == FRAME_LAST)
            phase_next = cij_pkg::PH_INIT;
        end
      cij_pkg::PH_INIT:
        if (initTick)
        begin
          initCnt_next = initCnt_reg + 1'b1;
          if (initCnt_reg == INIT_LAST)
            phase_next = cij_pkg::PH_USER;
        end
      cij_pkg::PH_USER:
        phase_next = cij_pkg::PH_USER;
      default:
        phase_next = cij_pkg::PH_IDLE;
    endcase
    // request low restarts from scratch
    if (!reqFilt_reg)
      phase_next = cij_pkg::PH_IDLE;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_reg    <= cij_pkg::PH_IDLE;
      frameCnt_reg <= '0;
      initCnt_reg  <= '0;
      opt_reg      <= '0;
      optValid_reg <= 1'b0;
    end
    else
    begin
      phase_reg    <= phase_next;
      frameCnt_reg <= frameCnt_next;
      initCnt_reg  <= initCnt_next;
      opt_reg      <= opt_next;
      optValid_reg <= optValid_next;
    end
  end

  // open drain: only ever pulls low
  assign initDoneOut = 1'b0;
  // live request gate: the phase reaches idle a cycle after the request drops, so an abort
  // from config or init would otherwise pull the pin low for one cycle
  assign initDoneOe  = optValid_reg && opt_reg[cij_pkg::OPT_INIT] &&
                       reqFilt_reg &&
                       (phase_reg == cij_pkg::PH_CONFIG ||
                        phase_reg == cij_pkg::PH_INIT);
  assign userMode    = phase_reg == cij_pkg::PH_USER;

  // pins act straight through gates, no clock in the path
  assign ioOe = (opt_reg[cij_pkg::OPT_GOE] && !global_output_enable) ?
                '0 : ioOeUser;
  assign userClear_n = !(opt_reg[cij_pkg::OPT_GCLR] &&
                         !global_register_clear_n);

  assign statusWord = {reqFilt_reg, optValid_reg, opt_reg, phase_reg};

  // test port, tck domain; status bits are slow levels, two flops each
  cij_pkg::cij_tap_t tap_reg, tap_next;
  logic [cij_pkg::ST_W-1:0] stSync1_reg, stSync2_reg;
  logic [cij_pkg::IR_W-1:0] irShift_reg, irShift_next, ir_reg, ir_next;
  logic [cij_pkg::ST_W-1:0] drShift_reg, drShift_next;
  logic            tdoNext, tdoOeNext;

  always_comb
  begin
    tap_next = tap_reg;
    case (tap_reg)
      cij_pkg::TAP_TLR:  tap_next = tms ? cij_pkg::TAP_TLR  : cij_pkg::TAP_RTI;
      cij_pkg::TAP_RTI:  tap_next = tms ? cij_pkg::TAP_SDR  : cij_pkg::TAP_RTI;
      cij_pkg::TAP_SDR:  tap_next = tms ? cij_pkg::TAP_SIR  : cij_pkg::TAP_CDR;
      cij_pkg::TAP_CDR:  tap_next = tms ? cij_pkg::TAP_E1DR : cij_pkg::TAP_SHDR;
      cij_pkg::TAP_SHDR: tap_next = tms ? cij_pkg::TAP_E1DR : cij_pkg::TAP_SHDR;
      cij_pkg::TAP_E1DR: tap_next = tms ? cij_pkg::TAP_UDR  : cij_pkg::TAP_PDR;
      cij_pkg::TAP_PDR:  tap_next = tms ? cij_pkg::TAP_E2DR : cij_pkg::TAP_PDR;
      cij_pkg::TAP_E2DR: tap_next = tms ? cij_pkg::TAP_UDR  : cij_pkg::TAP_SHDR;
      cij_pkg::TAP_UDR:  tap_next = tms ? cij_pkg::TAP_SDR  : cij_pkg::TAP_RTI;
      cij_pkg::TAP_SIR:  tap_next = tms ? cij_pkg::TAP_TLR  : cij_pkg::TAP_CIR;
      cij_pkg::TAP_CIR:  tap_next = tms ? cij_pkg::TAP_E1IR : cij_pkg::TAP_SHIR;
      cij_pkg::TAP_SHIR: tap_next = tms ? cij_pkg::TAP_E1IR : cij_pkg::TAP_SHIR;
      cij_pkg::TAP_E1IR: tap_next = tms ? cij_pkg::TAP_UIR  : cij_pkg::TAP_PIR;
      cij_pkg::TAP_PIR:  tap_next = tms ? cij_pkg::TAP_E2IR : cij_pkg::TAP_PIR;
      cij_pkg::TAP_E2IR: tap_next = tms ? cij_pkg::TAP_UIR  : cij_pkg::TAP_SHIR;
      cij_pkg::TAP_UIR:  tap_next = tms ? cij_pkg::TAP_SDR  : cij_pkg::TAP_RTI;
      default:           tap_next = cij_pkg::TAP_TLR;
    endcase
    irShift_next = irShift_reg;
    ir_next      = ir_reg;
    drShift_next = drShift_reg;
    case (tap_reg)
      cij_pkg::TAP_TLR:  ir_next = cij_pkg::IR_BYPASS;
      cij_pkg::TAP_CIR:  irShift_next = cij_pkg::IR_CAPT;
      cij_pkg::TAP_SHIR:
        irShift_next = {tdi, irShift_reg[cij_pkg::IR_W-1:1]};
      cij_pkg::TAP_UIR:  ir_next = irShift_reg;
      cij_pkg::TAP_CDR:
        drShift_next = (ir_reg == cij_pkg::IR_STATUS) ? stSync2_reg : '0;
      cij_pkg::TAP_SHDR:
        if (ir_reg == cij_pkg::IR_STATUS)
          drShift_next = {tdi, drShift_reg[cij_pkg::ST_W-1:1]};
        else
          drShift_next = {{(cij_pkg::ST_W-1){1'b0}}, tdi}; // bypass cell
      default:
        drShift_next = drShift_reg;
    endcase
    // value for the falling edge; only shift states drive the pin
    tdoOeNext = tap_reg == cij_pkg::TAP_SHIR ||
                tap_reg == cij_pkg::TAP_SHDR;
    tdoNext   = (tap_reg == cij_pkg::TAP_SHIR) ? irShift_reg[0] :
                drShift_reg[0];
  end

  always_ff @(posedge tck or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tap_reg     <= cij_pkg::TAP_TLR;
      stSync1_reg <= '0;
      stSync2_reg <= '0;
      irShift_reg <= '0;
      ir_reg      <= cij_pkg::IR_BYPASS;
      drShift_reg <= '0;
    end
    else
    begin
      tap_reg     <= tap_next;
      stSync1_reg <= statusWord;
      stSync2_reg <= stSync1_reg;
      irShift_reg <= irShift_next;
      ir_reg      <= ir_next;
      drShift_reg <= drShift_next;
    end
  end

  // falling edge keeps a half period of hold for the far side
  always_ff @(negedge tck or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tdoOut <= 1'b0;
      tdoOe  <= 1'b0;
    end
    else
    begin
      tdoOut <= tdoNext;
      tdoOe  <= tdoOeNext;
    end
  end
endmodule

/* cij_config_init_properties.sv */
// Purpose: port-level timing checks for cij_config_init
// Assumes: everything sampled on sys_clk, tck seen as a plain level
// Notes:   bound to the design from the foot of this file
module cij_config_init_properties #(
  parameter int IO_W = 8
) (
  // clock and reset
  input wire logic            sys_clk,
  input wire logic            arst_n,
  // register bus
  input wire logic            s_axi_awready,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic            s_axi_rvalid,
  // configuration pins
  input wire logic            configuration_request_n,
  input wire logic            initDoneOut,
  input wire logic            initDoneOe,
  input wire logic            userMode,
  // global overrides
  input wire logic            global_output_enable,
  input wire logic            global_register_clear_n,
  input wire logic [IO_W-1:0] ioOeUser,
  input wire logic [IO_W-1:0] ioOe,
  input wire logic            userClear_n,
  // test port
  input wire logic            tck,
  input wire logic            tdoOut,
  input wire logic            tdoOe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  // eight cycles covers the pin filter plus the idle step
  a_oe_idle_low: assert property (
    (!configuration_request_n) [*8] |-> !initDoneOe && !userMode)
    else $error("init-done pulled low while request held low");
  a_user_release: assert property (
    userMode |-> !initDoneOe)
    else $error("init-done still pulled low in user mode");
  a_open_drain: assert property (
    initDoneOut == 1'b0)
    else $error("init-done pin driven high");
  a_goe_pass: assert property (
    global_output_enable |-> ioOe == ioOeUser)
    else $error("output enables altered while override high");
  a_clear_pass: assert property (
    global_register_clear_n |-> userClear_n)
    else $error("register clear while clear input high");
  // tdo may only move on a falling test clock
  a_tdo_fall_only: assert property (
    (tck && $past(tck)) |-> $stable(tdoOut) && $stable(tdoOe))
    else $error("test data output moved while tck high");
  a_write_block: assert property (
    s_axi_bvalid |-> !s_axi_awready)
    else $error("write address accepted while response pending");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late or read address not blocked");

  c_user: cover property ($rose(userMode));
  c_drive: cover property ($rose(initDoneOe));
  c_shift: cover property ($rose(tdoOe));
endmodule

bind cij_config_init cij_config_init_properties #(.IO_W(IO_W)) u_chk (
  .sys_clk, .arst_n, .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .configuration_request_n, .initDoneOut,
  .initDoneOe, .userMode, .global_output_enable, .global_register_clear_n,
  .ioOeUser, .ioOe, .userClear_n, .tck, .tdoOut, .tdoOe
);

/* cij_config_init_tb.sv */
// Purpose: self-checking bench for cij_config_init
// Assumes: two frames, three init ticks paced by the user clock
// Notes:   bus tasks look at ready at the falling edge before the take
module cij_config_init_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int NF = 2;
  localparam int NI = 3;
  typedef struct {
    logic wr; logic [7:0] a; logic [31:0] d; logic [3:0] s;
    logic [1:0] r; logic [31:0] q; logic oe;
  } cij_row_t;
  logic        sys_clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, userMode;
  logic        configuration_request_n, user_startup_clock, initDoneOut;
  logic        initDoneOe, global_output_enable, global_register_clear_n;
  logic        userClear_n, tck, tms, tdi, tdoOut, tdoOe;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, ioOeUser, ioOe, v;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          bad_count, total_checks;
  int          initRises = 0;
  logic        pinWas;
  cij_row_t    rows [10];

  cij_config_init #(.NUM_FRAMES(NF), .INIT_CYCLES(NI), .IO_W(8)) uut (
    .sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .configuration_request_n, .user_startup_clock,
    .initDoneOut, .initDoneOe, .userMode, .global_output_enable,
    .global_register_clear_n, .ioOeUser, .ioOe, .userClear_n,
    .tck, .tms, .tdi, .tdoOut, .tdoOe);
  cij_jtag_host jtg (.tck, .tms, .tdi, .tdoOut, .tdoOe);

  task check(input string n, input logic [31:0] seen, input logic [31:0] e);
    total_checks++;
    if (seen !== e)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, seen);
    end
  endtask

  task results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] rs);
    logic ta, tw, tv;
    int   n;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tv = 1'b0;
    n = 0;
    while (!tv && n < 50)
    begin
      @(negedge sys_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tv = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    if (!tv) bad_count++;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] rs);
    logic ta, tv;
    int   n;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tv = 1'b0;
    n = 0;
    while (!tv && n < 50)
    begin
      @(negedge sys_clk);
      ta = s_axi_arvalid && s_axi_arready;
      tv = s_axi_rvalid;
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge sys_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_rready <= 1'b0;
    if (!tv) bad_count++;
  endtask

  // user clock slow enough for the pin filter
  task upulse();
    repeat (4) @(posedge sys_clk);
    user_startup_clock <= 1'b1;
    repeat (4) @(posedge sys_clk);
    user_startup_clock <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // far-side monitor: user mode shows as a rise on the pulled-up wire
  always @(posedge sys_clk)
  begin
    pinWas <= !initDoneOe;
    if (arst_n && !pinWas && !initDoneOe)
      initRises <= initRises + 1;
  end

  initial
  begin
    #100000;
    bad_count++;
    results();
  end

  initial
  begin
    // status: [1:0] phase, [5:2] options, [6] valid, [7] request
    rows = '{
      '{1, 8'h08, 32'h0, 4'hf, cij_pkg::RESP_SLVERR, 32'h0, 0},
      '{1, cij_pkg::OFF_STATUS, 32'h0, 4'hf, cij_pkg::RESP_SLVERR, 32'h0, 0},
      '{1, cij_pkg::OFF_DATA, 32'hf, 4'h3, cij_pkg::RESP_SLVERR, 32'h0, 0},
      '{0, 8'h08, 32'h0, 4'h0, cij_pkg::RESP_SLVERR, 32'h0, 0},
      '{0, cij_pkg::OFF_DATA, 32'h0, 4'h0, cij_pkg::RESP_OKAY, 32'h0, 0},
      '{0, cij_pkg::OFF_STATUS, 32'h0, 4'h0, cij_pkg::RESP_OKAY, 32'h81, 0},
      '{1, cij_pkg::OFF_DATA, 32'hf, 4'hf, cij_pkg::RESP_OKAY, 32'h0, 1},
      '{0, cij_pkg::OFF_STATUS, 32'h0, 4'h0, cij_pkg::RESP_OKAY, 32'hfd, 1},
      '{1, cij_pkg::OFF_DATA, 32'h0, 4'hf, cij_pkg::RESP_OKAY, 32'h0, 1},
      '{0, cij_pkg::OFF_STATUS, 32'h0, 4'h0, cij_pkg::RESP_OKAY, 32'hfe, 1}};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {s_axi_rready, user_startup_clock, arst_n} = 3'h0;
    {configuration_request_n, global_output_enable} = 2'h3;
    global_register_clear_n = 1'b1;
    ioOeUser = 8'ha5;
    bad_count = 0;
    total_checks = 0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    foreach (rows[i])
    begin
      if (rows[i].wr)
        axi_wr(rows[i].a, rows[i].d, rows[i].s, r);
      else
        axi_rd(rows[i].a, q, r);
      check("resp", 32'(r), 32'(rows[i].r));
      if (!rows[i].wr) check("rdata", q, rows[i].q);
      @(negedge sys_clk);
      check("initDoneOe", 32'(initDoneOe), 32'(rows[i].oe));
    end
    // overrides must act with no clock edge in between
    @(posedge sys_clk);
    {global_output_enable, global_register_clear_n} <= 2'h0;
    #1 check("ioOe off", 32'(ioOe), 32'h0);
    check("clear on", 32'(userClear_n), 32'h0);
    @(posedge sys_clk);
    {global_output_enable, global_register_clear_n} <= 2'h3;
    #1 check("ioOe on", 32'(ioOe), 32'ha5);
    check("clear off", 32'(userClear_n), 32'h1);
    repeat (NI - 1) upulse();
    repeat (20) @(posedge sys_clk);
    check("early user", 32'(userMode), 32'h0);
    upulse();
    repeat (4) @(posedge sys_clk);
    check("userMode", 32'(userMode), 32'h1);
    check("released", 32'(initDoneOe), 32'h0);
    check("init edge", 32'(initRises), 32'd1);
    jtg.reset_tap();
    jtg.scan(1'b1, {4'h0, cij_pkg::IR_STATUS}, 4, v);
    check("ir capture", 32'(v), 32'h1);
    jtg.scan(1'b0, 8'h00, 8, v);
    check("dr status", 32'(v), 32'hff);
    jtg.scan(1'b1, {4'h0, cij_pkg::IR_BYPASS}, 4, v);
    jtg.scan(1'b0, 8'h5a, 8, v);
    check("bypass", 32'(v), 32'hb4);
    check("tdo shifts", 32'(jtg.oeCnt), 32'd24);
    check("tdo idle", 32'(tdoOe), 32'h0);
    @(posedge sys_clk);
    configuration_request_n <= 1'b0;
    global_output_enable <= 1'b0;
    repeat (8) @(posedge sys_clk);
    check("abort user", 32'(userMode), 32'h0);
    check("abort pin", 32'(initDoneOe), 32'h0);
    check("abort goe", 32'(ioOe), 32'ha5);
    axi_rd(cij_pkg::OFF_STATUS, q, r);
    check("idle status", q, 32'h0);
    check("no false edge", 32'(initRises), 32'd1);
    // relaunch, then reset in mid-configuration with the pin pulled low
    configuration_request_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    axi_wr(cij_pkg::OFF_DATA, 32'h2, cij_pkg::STRB_ALL, r);
    @(negedge sys_clk);
    check("relaunch", 32'(initDoneOe), 32'h1);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    #1 check("rst pin", 32'(initDoneOe), 32'h0);
    check("rst pin data", 32'(initDoneOut), 32'h0);
    check("rst tdo", 32'(tdoOe), 32'h0);
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    axi_rd(cij_pkg::OFF_STATUS, q, r);
    check("rst status", q, 32'h81);
    results();
  end
endmodule

/* cij_jtag_host.sv */
// Purpose: behavioural test controller on the boundary-scan pins
// Assumes: 32 ns test clock, run only inside a tap reset or a scan
// Notes:   tdo is read just before each rising tck
module cij_jtag_host (
  // test port pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input wire logic  tdoOut,
  input wire logic  tdoOe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lastTdo;
  int   oeCnt;

  // clock parked at ground, pins steady until a tap reset or a scan starts
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    lastTdo = 1'b0;
    oeCnt = 0;
  end

  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #16;
    // an undriven line shows no stale value
    q = tdoOe ? tdoOut : ~lastTdo;
    if (tdoOe)
    begin
      lastTdo = tdoOut;
      oeCnt++;
    end
    tck = 1'b1;
    #16;
    tck = 1'b0;
  endtask

  task automatic reset_tap();
    logic q;
    #1;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask

  // starts and ends in run-test/idle; n bits, lsb first
  task automatic scan(input logic ir, input logic [7:0] din, input int n,
                      output logic [7:0] dout);
    logic q;
    dout = 8'h00;
    step(1'b1, 1'b0, q);
    if (ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule

/* cij_pkg.sv */
// Purpose: shared constants for the config/init status and test port block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes:   tap state codes follow the usual boundary-scan encoding
package cij_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_DATA   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  // option bits carried in the first frame word
  localparam int OPT_UCLK = 0;
  localparam int OPT_INIT = 1;
  localparam int OPT_GOE  = 2;
  localparam int OPT_GCLR = 3;
  localparam int OPT_W    = 4;
  // status word layout
  localparam int ST_PHASE = 0;
  localparam int ST_OPT   = 2;
  localparam int ST_OPTV  = 6;
  localparam int ST_REQN  = 7;
  localparam int ST_W     = 8;
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] STRB_ALL    = 4'hf;
  // test port instructions
  localparam int         IR_W      = 4;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_STATUS = 4'h2;
  localparam logic [3:0] IR_CAPT   = 4'h1;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_CONFIG = 2'b01,
    PH_INIT   = 2'b10,
    PH_USER   = 2'b11
  } cij_phase_t;

  typedef enum logic [3:0] {
    TAP_TLR  = 4'b1111, TAP_RTI  = 4'b1100, TAP_SDR  = 4'b0111,
    TAP_CDR  = 4'b0110, TAP_SHDR = 4'b0010, TAP_E1DR = 4'b0001,
    TAP_PDR  = 4'b0011, TAP_E2DR = 4'b0000, TAP_UDR  = 4'b0101,
    TAP_SIR  = 4'b0100, TAP_CIR  = 4'b1110, TAP_SHIR = 4'b1010,
    TAP_E1IR = 4'b1001, TAP_PIR  = 4'b1011, TAP_E2IR = 4'b1000,
    TAP_UIR  = 4'b1101
  } cij_tap_t;
endpackage
